// ==== design/osd_place_cfg.svh ====
`ifndef OSD_PLACE_CFG_SVH
`define OSD_PLACE_CFG_SVH
// ==========================================================
// register offsets
`define ADDR_W1_HSTART   16'h8410
`define ADDR_W1_VSTART   16'h8411
`define ADDR_W1_WIDE0    16'h8414
`define ADDR_W1_WIDE1    16'h8415
`define ADDR_W1_WIDE2    16'h8416
`define ADDR_W1_WIDE3    16'h8417
`define ADDR_W2_HSTART   16'h8418
`define ADDR_W2_VSTART   16'h8419
`define ADDR_W2_BASE_LO  16'h841A
`define ADDR_W2_BASE_HI  16'h841B
`define ADDR_W2_WIDE0    16'h841C
`define ADDR_W2_WIDE1    16'h841D
`define ADDR_W2_WIDE2    16'h841E
`define ADDR_W2_WIDE3    16'h841F
// ==========================================================
// reset values
`define RESET_BYTE       8'h00
`define RESET_WIDE       32'h0000_0000
`define RESET_BASE       9'h000
// ==========================================================
// placement and width figures
`define H_SCALE_SHIFT    2
`define H_OFFSET         11'h01E
`define H_FIRST_USABLE   11'h02A
`define V_SCALE_SHIFT    1
`define HEIGHT_SHIFT     2
`define FONT_LAST        4'hB
`define WIDE_COLS        6'h20
`endif

// ==== design/osd_place_pkg.sv ====
package osd_place_pkg;
  // ==========================================================
  // settings of one window, as software programs them; window 1 base comes from WINDOW1_BASE instead
  typedef struct packed {
    logic [7:0]  hstart;
    logic [7:0]  vstart;
    logic [31:0] wide;
    logic [8:0]  base;
  } window_cfg_type;
  // ==========================================================
  // one fetch slot of the column stepper
  typedef struct packed {
    logic        fetch;
    logic [8:0]  ram_addr;
    logic [3:0]  font_col;
    logic [5:0]  column;
    logic        wide;
  } fetch_type;
  // ==========================================================
  typedef enum logic [1:0] {
    SPAN_IDLE = 2'b01,
    SPAN_RUN  = 2'b10
  } span_state_type;
endpackage : osd_place_pkg

// ==== design/osd_column_stepper.sv ====
`timescale 1ns/10ps
`include "osd_place_cfg.svh"
module osd_column_stepper #(
  parameter int COLS = 40
) (
  input  wire logic                   clock,      // osd pixel clock
  input  wire logic                   reset_n,    // sync reset
  input  wire logic                   start,      // launch one row span
  input  wire logic [8:0]             row_base,   // address of row start code
  input  wire logic [31:0]            wide_mask,  // per column double width
  output osd_place_pkg::fetch_type    slot        // current fetch slot
);
  import osd_place_pkg::*;

  span_state_type state_q;
  logic [5:0]     col_q;
  logic [3:0]     font_q;
  logic           phase_q;
  logic [8:0]     addr_q;
  logic           wide;

  // ==========================================================
  // width of current column; past the 32nd always normal
  assign wide = (col_q < `WIDE_COLS) && wide_mask[col_q[4:0]]; // R14

  // ==========================================================
  // span state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= SPAN_IDLE;
    end else begin
      case (state_q)
        SPAN_IDLE: if (start) state_q <= SPAN_RUN;
        SPAN_RUN: begin
          if (font_q == `FONT_LAST && !(wide && !phase_q) && col_q == 6'(COLS - 1)) begin
            state_q <= SPAN_IDLE;
          end
        end
        default: state_q <= SPAN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // font pixel and column stepping; wide columns repeat each pixel
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      col_q   <= 6'h00;
      font_q  <= 4'h0;
      phase_q <= 1'b0;
      addr_q  <= 9'h000;
    end else if (state_q == SPAN_IDLE) begin
      if (start) begin
        col_q   <= 6'h00;
        font_q  <= 4'h0;
        phase_q <= 1'b0;
        addr_q  <= 9'(row_base + 9'h001); // R10
      end
    end else if (wide && !phase_q) begin
      phase_q <= 1'b1; // R13 R16
    end else begin
      phase_q <= 1'b0;
      if (font_q == `FONT_LAST) begin // R12
        font_q <= 4'h0;
        col_q  <= 6'(col_q + 6'h01);
        addr_q <= 9'(addr_q + 9'h001);
      end else begin
        font_q <= 4'(font_q + 4'h1); // R16
      end
    end
  end

  assign slot.fetch    = (state_q == SPAN_RUN);
  assign slot.ram_addr = addr_q;
  assign slot.font_col = font_q;
  assign slot.column   = col_q;
  assign slot.wide     = wide && (state_q == SPAN_RUN);
endmodule : osd_column_stepper

// ==== design/osd_window_placement.sv ====
`timescale 1ns/10ps
`include "osd_place_cfg.svh"
// Contract
// R01 - two windows, each alone or both together
// R02 - horizontal start counts osd pixels
// R03 - left edge at four times start plus thirty
// R04 - earliest working left edge about forty-two
// R05 - software keeps horizontal start above two
// R06 - top edge at twice vertical start
// R07 - character line spans scaled scan lines
// R08 - software keeps windows inside active video
// R09 - window two fetches from 9-bit base
// R10 - base location holds first row start code
// R11 - software writes zero to reserved base bits
// R12 - cleared column bit gives twelve pixel column
// R13 - set column bit doubles each font pixel
// R14 - columns past thirty-second always normal width
// R15 - height setting is osd lines over four
// R16 - wide column advances font index every second pixel
module osd_window_placement #(
  parameter int         COLS         = 40,      // characters per row
  parameter int         ROWS         = 16,      // rows per window
  parameter int         ROW_LINES    = 18,      // character lines per row
  parameter logic [8:0] WINDOW1_BASE = 9'h000   // window 1 row start address
) (
  input  wire logic        CLOCK,                     // osd pixel clock
  input  wire logic        RESETN,                    // sync reset
  input  wire logic [15:0] REG_ADDR,                  // register address
  input  wire logic        REG_WRITE,                 // write strobe
  input  wire logic [7:0]  REG_WDATA,                 // write data
  input  wire logic        REG_READ,                  // read strobe
  output logic      [7:0]  REG_RDATA,                 // read data
  input  wire logic        H_FLYBACK,                 // horizontal flyback
  input  wire logic        V_FLYBACK,                 // vertical flyback
  input  wire logic [7:0]  CHARACTER_HEIGHT_SETTING,  // osd lines over four
  input  wire logic        WINDOW1_ENABLE,            // show window 1
  input  wire logic        WINDOW2_ENABLE,            // show window 2
  output logic             WINDOW1_FETCH,             // window 1 fetching
  output logic             WINDOW2_FETCH,             // window 2 fetching
  output logic      [8:0]  WINDOW1_RAM_ADDR,          // window 1 page address
  output logic      [8:0]  WINDOW2_RAM_ADDR,          // window 2 page address
  output logic      [3:0]  WINDOW1_FONT_COL,          // window 1 font column
  output logic      [3:0]  WINDOW2_FONT_COL,          // window 2 font column
  output logic      [4:0]  WINDOW1_FONT_LINE,         // window 1 line in row
  output logic      [4:0]  WINDOW2_FONT_LINE,         // window 2 line in row
  output logic             WINDOW1_ACTIVE,            // window 1 on screen
  output logic             WINDOW2_ACTIVE             // window 2 on screen
);
  import osd_place_pkg::*;

  localparam int PIPE = int'(`H_FIRST_USABLE - `H_OFFSET);

  // ==========================================================
  // register storage
  logic [7:0]     w1_hstart_q;
  logic [7:0]     w1_vstart_q;
  logic [31:0]    w1_wide_q;
  logic [7:0]     w2_hstart_q;
  logic [7:0]     w2_vstart_q;
  logic [31:0]    w2_wide_q;
  logic [8:0]     w2_base_q;
  window_cfg_type cfg [2];

  // ==========================================================
  // raster tracking
  logic           h_prev_q;
  logic           v_prev_q;
  logic           h_edge;
  logic           v_edge;
  logic [10:0]    pix_q;
  logic [10:0]    scan_count_q;
  logic [10:0]    frame_lines_q;
  logic [11:0]    acc_q;
  logic [11:0]    acc_sum;
  logic [11:0]    acc_step;
  logic [8:0]     osd_line_q;
  logic           line_tick;

  // ==========================================================
  // per window outputs gathered for the output stage
  fetch_type      slot    [2];
  logic [4:0]     row_line [2];
  logic           enable  [2];

  assign enable[0] = WINDOW1_ENABLE; // R01
  assign enable[1] = WINDOW2_ENABLE; // R01

  // ==========================================================
  // register writes; only the low base bit is kept in the high byte
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      w1_hstart_q <= `RESET_BYTE;
      w1_vstart_q <= `RESET_BYTE;
      w1_wide_q   <= `RESET_WIDE;
      w2_hstart_q <= `RESET_BYTE;
      w2_vstart_q <= `RESET_BYTE;
      w2_wide_q   <= `RESET_WIDE;
      w2_base_q   <= `RESET_BASE;
    end else if (REG_WRITE) begin
      if (REG_ADDR == `ADDR_W1_HSTART) begin
        w1_hstart_q <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W1_VSTART) begin
        w1_vstart_q <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W1_WIDE0) begin
        w1_wide_q[7:0] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W1_WIDE1) begin
        w1_wide_q[15:8] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W1_WIDE2) begin
        w1_wide_q[23:16] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W1_WIDE3) begin
        w1_wide_q[31:24] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_HSTART) begin
        w2_hstart_q <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_VSTART) begin
        w2_vstart_q <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_BASE_LO) begin
        w2_base_q[7:0] <= REG_WDATA; // R09
      end else if (REG_ADDR == `ADDR_W2_BASE_HI) begin
        w2_base_q[8] <= REG_WDATA[0]; // R09 R11
      end else if (REG_ADDR == `ADDR_W2_WIDE0) begin
        w2_wide_q[7:0] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_WIDE1) begin
        w2_wide_q[15:8] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_WIDE2) begin
        w2_wide_q[23:16] <= REG_WDATA;
      end else if (REG_ADDR == `ADDR_W2_WIDE3) begin
        w2_wide_q[31:24] <= REG_WDATA;
      end
    end
  end

  // ==========================================================
  // register reads; reserved base bits and unmapped addresses give zero
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_READ) begin
      if (REG_ADDR == `ADDR_W1_HSTART) begin
        REG_RDATA <= w1_hstart_q;
      end else if (REG_ADDR == `ADDR_W1_VSTART) begin
        REG_RDATA <= w1_vstart_q;
      end else if (REG_ADDR == `ADDR_W1_WIDE0) begin
        REG_RDATA <= w1_wide_q[7:0];
      end else if (REG_ADDR == `ADDR_W1_WIDE1) begin
        REG_RDATA <= w1_wide_q[15:8];
      end else if (REG_ADDR == `ADDR_W1_WIDE2) begin
        REG_RDATA <= w1_wide_q[23:16];
      end else if (REG_ADDR == `ADDR_W1_WIDE3) begin
        REG_RDATA <= w1_wide_q[31:24];
      end else if (REG_ADDR == `ADDR_W2_HSTART) begin
        REG_RDATA <= w2_hstart_q;
      end else if (REG_ADDR == `ADDR_W2_VSTART) begin
        REG_RDATA <= w2_vstart_q;
      end else if (REG_ADDR == `ADDR_W2_BASE_LO) begin
        REG_RDATA <= w2_base_q[7:0];
      end else if (REG_ADDR == `ADDR_W2_BASE_HI) begin
        REG_RDATA <= {7'h00, w2_base_q[8]};
      end else if (REG_ADDR == `ADDR_W2_WIDE0) begin
        REG_RDATA <= w2_wide_q[7:0];
      end else if (REG_ADDR == `ADDR_W2_WIDE1) begin
        REG_RDATA <= w2_wide_q[15:8];
      end else if (REG_ADDR == `ADDR_W2_WIDE2) begin
        REG_RDATA <= w2_wide_q[23:16];
      end else if (REG_ADDR == `ADDR_W2_WIDE3) begin
        REG_RDATA <= w2_wide_q[31:24];
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // ==========================================================
  // settings bundled per window
  assign cfg[0] = '{hstart: w1_hstart_q, vstart: w1_vstart_q, wide: w1_wide_q, base: WINDOW1_BASE};
  assign cfg[1] = '{hstart: w2_hstart_q, vstart: w2_vstart_q, wide: w2_wide_q, base: w2_base_q};

  // ==========================================================
  // flyback edges; inputs are already synchronous
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      h_prev_q <= 1'b0;
      v_prev_q <= 1'b0;
    end else begin
      h_prev_q <= H_FLYBACK;
      v_prev_q <= V_FLYBACK;
    end
  end

  assign h_edge = H_FLYBACK && !h_prev_q;
  assign v_edge = V_FLYBACK && !v_prev_q;

  // ==========================================================
  // osd pixel count from horizontal flyback; saturates, never wraps
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pix_q <= 11'h000;
    end else if (h_edge) begin
      pix_q <= 11'h000; // R02
    end else if (pix_q != 11'h7FF) begin
      pix_q <= 11'(pix_q + 11'h001);
    end
  end

  // ==========================================================
  // scan lines per frame, measured over the previous frame
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      scan_count_q  <= 11'h000;
      frame_lines_q <= 11'h001;
    end else if (v_edge) begin
      scan_count_q  <= 11'h000;
      frame_lines_q <= (scan_count_q == 11'h000) ? 11'h001 : scan_count_q;
    end else if (h_edge && scan_count_q != 11'h7FF) begin
      scan_count_q <= 11'(scan_count_q + 11'h001);
    end
  end

  // ==========================================================
  // constant height lines: setting times four lines spread over the
  // frame, so one character line spans frame/(4*setting) scan lines
  assign acc_step = {2'b00, CHARACTER_HEIGHT_SETTING, 2'b00}; // R15
  assign acc_sum  = 12'(acc_q + acc_step);
  assign line_tick = h_edge && !v_edge && (acc_sum >= {1'b0, frame_lines_q}); // R07

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      acc_q      <= 12'h000;
      osd_line_q <= 9'h000;
    end else if (v_edge) begin
      acc_q      <= 12'h000;
      osd_line_q <= 9'h000;
    end else if (line_tick) begin
      // step above frame length gives at most one line per scan line
      acc_q <= (12'(acc_sum - {1'b0, frame_lines_q}) >= {1'b0, frame_lines_q}) ? 12'h000
               : 12'(acc_sum - {1'b0, frame_lines_q});
      if (osd_line_q != 9'h1FF) begin
        osd_line_q <= 9'(osd_line_q + 9'h001); // R07
      end
    end else if (h_edge) begin
      acc_q <= acc_sum;
    end
  end

  // ==========================================================
  // per window placement; both run independently
  for (genvar w = 0; w < 2; w++) begin : g_win
    logic [10:0] left_edge;
    logic [10:0] launch;
    logic [8:0]  top_line;
    logic        vert_q;
    logic [4:0]  line_q;
    logic [4:0]  row_q;
    logic [8:0]  row_base_q;
    logic        start;

    // left edge four times start plus thirty; fetch leads by the pipe
    assign left_edge = 11'({cfg[w].hstart, 2'b00}) + `H_OFFSET; // R03
    // below the first usable edge the window launches as if at the first usable edge
    assign launch = (left_edge >= `H_FIRST_USABLE) ? 11'(left_edge - 11'(PIPE))
                    : `H_OFFSET; // R04
    assign top_line = {cfg[w].vstart, 1'b0}; // R06

    // vertical span and row walk on each constant height line
    always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
        vert_q     <= 1'b0;
        line_q     <= 5'h00;
        row_q      <= 5'h00;
        row_base_q <= 9'h000;
      end else if (v_edge) begin
        vert_q <= (top_line == 9'h000);
        line_q <= 5'h00;
        row_q  <= 5'h00;
        row_base_q <= cfg[w].base; // R09
      end else if (line_tick) begin
        if (9'(osd_line_q + 9'h001) == top_line) begin
          vert_q     <= 1'b1; // R06
          line_q     <= 5'h00;
          row_q      <= 5'h00;
          row_base_q <= cfg[w].base; // R09 R10
        end else if (vert_q) begin
          if (line_q == 5'(ROW_LINES - 1)) begin
            line_q     <= 5'h00;
            row_base_q <= 9'(row_base_q + 9'(COLS + 1));
            if (row_q == 5'(ROWS - 1)) begin
              vert_q <= 1'b0;
            end else begin
              row_q <= 5'(row_q + 5'h01);
            end
          end else begin
            line_q <= 5'(line_q + 5'h01);
          end
        end
      end
    end

    assign start = enable[w] && vert_q && (pix_q == launch) && !h_edge; // R01
    assign row_line[w] = line_q;

    osd_column_stepper #(
      .COLS (COLS)
    ) u_stepper (
      .clock     (CLOCK),
      .reset_n   (RESETN),
      .start     (start),
      .row_base  (row_base_q),
      .wide_mask (cfg[w].wide),
      .slot      (slot[w])
    );
  end

  // ==========================================================
  // fetch side outputs, registered
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      WINDOW1_FETCH     <= 1'b0;
      WINDOW2_FETCH     <= 1'b0;
      WINDOW1_RAM_ADDR  <= 9'h000;
      WINDOW2_RAM_ADDR  <= 9'h000;
      WINDOW1_FONT_COL  <= 4'h0;
      WINDOW2_FONT_COL  <= 4'h0;
      WINDOW1_FONT_LINE <= 5'h00;
      WINDOW2_FONT_LINE <= 5'h00;
    end else begin
      WINDOW1_FETCH     <= slot[0].fetch;
      WINDOW2_FETCH     <= slot[1].fetch;
      WINDOW1_RAM_ADDR  <= slot[0].ram_addr;
      WINDOW2_RAM_ADDR  <= slot[1].ram_addr; // R09
      WINDOW1_FONT_COL  <= slot[0].font_col;
      WINDOW2_FONT_COL  <= slot[1].font_col;
      WINDOW1_FONT_LINE <= row_line[0];
      WINDOW2_FONT_LINE <= row_line[1];
    end
  end

  // ==========================================================
  // display pipe: fetch slots reach the screen PIPE pixels later
  logic [PIPE-1:0] pipe1_q;
  logic [PIPE-1:0] pipe2_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pipe1_q <= '0;
      pipe2_q <= '0;
    end else begin
      pipe1_q <= {pipe1_q[PIPE-2:0], slot[0].fetch}; // R04
      pipe2_q <= {pipe2_q[PIPE-2:0], slot[1].fetch}; // R04
    end
  end

  assign WINDOW1_ACTIVE = pipe1_q[PIPE-1];
  assign WINDOW2_ACTIVE = pipe2_q[PIPE-1];
endmodule : osd_window_placement

// ==== testbench/osd_window_placement_sva.sv ====
`timescale 1ns/10ps
// ==========================================================
// port checker for the window placement block
module osd_window_placement_sva (
  input wire logic        CLOCK,             // pixel clock
  input wire logic        RESETN,            // sync reset
  input wire logic [15:0] REG_ADDR,          // register address
  input wire logic        REG_WRITE,         // write strobe
  input wire logic [7:0]  REG_WDATA,         // write data
  input wire logic        REG_READ,          // read strobe
  input wire logic [7:0]  REG_RDATA,         // read data
  input wire logic        WINDOW1_FETCH,     // window 1 fetching
  input wire logic        WINDOW2_FETCH,     // window 2 fetching
  input wire logic [3:0]  WINDOW1_FONT_COL,  // window 1 font column
  input wire logic [3:0]  WINDOW2_FONT_COL,  // window 2 font column
  input wire logic        WINDOW1_ACTIVE,    // window 1 on screen
  input wire logic        WINDOW2_ACTIVE     // window 2 on screen
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // ==========================================================
  // register port
  a_reset_quiet: assert property (disable iff (1'b0) !RESETN |=> !WINDOW1_FETCH && !WINDOW2_FETCH
    && !WINDOW1_ACTIVE && !WINDOW2_ACTIVE && REG_RDATA == 8'h00) else $error("outputs busy after reset");
  a_rdata_holds: assert property (!REG_READ |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  a_hole_reads_zero: assert property (REG_READ && REG_ADDR inside {16'h8412, 16'h8413, 16'h8420}
    |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  a_base_hi_bits: assert property (REG_READ && REG_ADDR == 16'h841B |=> REG_RDATA[7:1] == 7'h00)
    else $error("reserved base bits read back");
  a_hstart_readback: assert property (REG_WRITE && REG_ADDR == 16'h8410 ##1 !REG_WRITE
    ##1 REG_READ && !REG_WRITE && REG_ADDR == 16'h8410 |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("start value not read back");
  // ==========================================================
  // span timing: pixel pipe is a fixed eleven cycles behind the fetch
  a_active_follows: assert property ($rose(WINDOW1_FETCH) |-> ##11 $rose(WINDOW1_ACTIVE))
    else $error("window 1 pixels late or early");
  a_font_range: assert property (WINDOW1_FETCH |-> WINDOW1_FONT_COL <= 4'hB)
    else $error("font index past eleven");
  a_font_step: assert property (WINDOW1_FETCH && $past(WINDOW1_FETCH) |-> WINDOW1_FONT_COL ==
    $past(WINDOW1_FONT_COL) || WINDOW1_FONT_COL == $past(WINDOW1_FONT_COL) + 4'h1
    || ($past(WINDOW1_FONT_COL) == 4'hB && WINDOW1_FONT_COL == 4'h0)) else $error("font index jumped");
  // a wide column repeats each index once, never twice
  a_wide_hold: assert property (WINDOW2_FETCH && $past(WINDOW2_FETCH) && $stable(WINDOW2_FONT_COL)
    |=> !(WINDOW2_FETCH && $stable(WINDOW2_FONT_COL))) else $error("font pixel held too long");
endmodule : osd_window_placement_sva

bind osd_window_placement osd_window_placement_sva osd_window_placement_sva_i (.CLOCK(CLOCK), .RESETN(RESETN),
  .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_WDATA(REG_WDATA), .REG_READ(REG_READ),
  .REG_RDATA(REG_RDATA), .WINDOW1_FETCH(WINDOW1_FETCH), .WINDOW2_FETCH(WINDOW2_FETCH),
  .WINDOW1_FONT_COL(WINDOW1_FONT_COL), .WINDOW2_FONT_COL(WINDOW2_FONT_COL),
  .WINDOW1_ACTIVE(WINDOW1_ACTIVE), .WINDOW2_ACTIVE(WINDOW2_ACTIVE));

// ==== testbench/osd_host_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// monitor controller model driving the register port
module osd_host_model (
  input  wire logic        CLOCK,      // pixel clock
  output logic      [15:0] REG_ADDR,   // register address
  output logic             REG_WRITE,  // write strobe
  output logic      [7:0]  REG_WDATA,  // write data
  output logic             REG_READ,   // read strobe
  input  wire logic [7:0]  REG_RDATA   // read data
);
  // idle bus at time zero
  initial begin
    REG_ADDR  = 16'h0000;
    REG_WDATA = 8'h00;
    REG_WRITE = 1'b0;
    REG_READ  = 1'b0;
  end
  // one write over one rising edge; released lines flip so stale values never look valid
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
    @(negedge CLOCK);
    REG_ADDR  = addr;
    REG_WDATA = data;
    REG_WRITE = 1'b1;
    @(negedge CLOCK);
    REG_WRITE = 1'b0;
    REG_ADDR  = ~addr;
    REG_WDATA = ~data;
  endtask : write_reg
  // one read; data is taken a full cycle after the strobe drops
  task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
    @(negedge CLOCK);
    REG_ADDR = addr;
    REG_READ = 1'b1;
    @(negedge CLOCK);
    REG_READ = 1'b0;
    REG_ADDR = ~addr;
    @(negedge CLOCK);
    data = REG_RDATA;
  endtask : read_reg
endmodule : osd_host_model

// ==== testbench/osd_window_placement_test.sv ====
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module osd_window_placement_test;
  localparam int LINE = 1000;  // cycles per scan line, room for a full wide span
  logic        CLOCK = 1'b0;
  logic        RESETN = 1'b0;
  logic        H_FLYBACK = 1'b0;
  logic        V_FLYBACK = 1'b0;
  logic [7:0]  HEIGHT = 8'hFF;  // one osd line per scan line
  logic        EN1 = 1'b0;
  logic        EN2 = 1'b0;
  logic [15:0] REG_ADDR;
  logic        REG_WRITE, REG_READ;
  logic [7:0]  REG_WDATA, REG_RDATA, rd;
  logic        f1, f2, act1, act2;
  logic [4:0]  l1, fl;
  logic [8:0]  a1, a2;
  logic [8:0]  addr [2];
  int          err_count = 0;
  int          total_checks = 0;
  int          first_line [2], lines [2], pos [2], len [2], last [2], on [2];
  int          ref_pos;
  // ==========================================================
  always #50 CLOCK = ~CLOCK;
  osd_window_placement #(.ROWS(1), .ROW_LINES(2)) osd_window_placement_i (.CLOCK(CLOCK), .RESETN(RESETN),
    .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_WDATA(REG_WDATA), .REG_READ(REG_READ),
    .REG_RDATA(REG_RDATA), .H_FLYBACK(H_FLYBACK), .V_FLYBACK(V_FLYBACK), .CHARACTER_HEIGHT_SETTING(HEIGHT),
    .WINDOW1_ENABLE(EN1), .WINDOW2_ENABLE(EN2), .WINDOW1_FETCH(f1), .WINDOW2_FETCH(f2),
    .WINDOW1_RAM_ADDR(a1), .WINDOW2_RAM_ADDR(a2), .WINDOW1_FONT_COL(), .WINDOW2_FONT_COL(),
    .WINDOW1_FONT_LINE(l1), .WINDOW2_FONT_LINE(), .WINDOW1_ACTIVE(act1), .WINDOW2_ACTIVE(act2));
  osd_host_model osd_host_model_i (.CLOCK(CLOCK), .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE),
    .REG_WDATA(REG_WDATA), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA));
  // ==========================================================
  // program one window: start, vertical start, four width bytes
  task automatic cfg(input logic [15:0] at, input logic [7:0] h, input logic [7:0] v, input logic [31:0] w);
    osd_host_model_i.write_reg(at, h);
    osd_host_model_i.write_reg(at + 16'h0001, v);
    for (int b = 0; b < 4; b++) begin
      osd_host_model_i.write_reg(at + 16'h0004 + 16'(b), w[8*b +: 8]);
    end
  endtask : cfg
  // one frame: flyback line then five lines; records where each window fetches
  task automatic run_frame();
    first_line = '{-1, -1};
    pos = '{-1, -1};
    on = '{0, 0};
    lines = '{0, 0};
    len = '{0, 0};
    last = '{-1, -1};
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < LINE; i++) begin
        @(negedge CLOCK);
        H_FLYBACK = (i < 4);
        V_FLYBACK = (n == 0) && (i >= 10) && (i < 14);
        for (int w = 0; w < 2; w++) begin
          if ((w == 0 ? act1 : act2) === 1'b1) on[w]++;
          if ((w == 0 ? f1 : f2) === 1'b1) begin
            if (first_line[w] < 0) begin
              first_line[w] = n;
              pos[w] = i;
              addr[w] = (w == 0) ? a1 : a2;
            end
            if (first_line[w] == n) len[w]++;
            if (last[w] != n) lines[w]++;
            last[w] = n;
            if (w == 0) fl = l1;
          end
        end
      end
    end
  endtask : run_frame
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  initial begin
    repeat (3) @(negedge CLOCK);
    RESETN = 1'b1;
    // reset values, holes included
    for (int a = 'h8410; a <= 'h8420; a++) begin
      osd_host_model_i.read_reg(16'(a), rd);
      `CHECK("reset value", 8'h00, rd)
    end
    for (int a = 'h8410; a <= 'h8420; a++) begin
      osd_host_model_i.write_reg(16'(a), 8'(a) ^ 8'h5A);
    end
    // reserved base bits and holes never stick
    for (int a = 'h8410; a <= 'h8420; a++) begin
      osd_host_model_i.read_reg(16'(a), rd);
      `CHECK("read", (a inside {'h8412, 'h8413, 'h8420}) ? 8'h00 : (a == 'h841B) ? 8'h01 : 8'(a) ^ 8'h5A, rd)
    end
    // write then read straight back
    osd_host_model_i.write_reg(16'h8410, 8'hA5);
    osd_host_model_i.read_reg(16'h8410, rd);
    `CHECK("hstart", 8'hA5, rd)
    // both windows, starts above two, windows kept in active video
    cfg(16'h8410, 8'h03, 8'h00, 32'h0000_0000);
    cfg(16'h8418, 8'h0A, 8'h01, 32'hFFFF_FFFF);
    osd_host_model_i.write_reg(16'h841A, 8'h55);
    osd_host_model_i.write_reg(16'h841B, 8'h01);
    EN1 = 1'b1;
    EN2 = 1'b1;
    run_frame();
    run_frame();
    `CHECK("w1 normal span", 480, len[0])
    `CHECK("w2 wide span", 864, len[1])
    `CHECK("start spacing", 28, pos[1] - pos[0])
    `CHECK("line spacing", 2, first_line[1] - first_line[0])
    `CHECK("w1 first addr", 9'h001, addr[0])
    `CHECK("w2 first addr", 9'h156, addr[1])
    `CHECK("equal heights", lines[0], lines[1])
    `CHECK("w1 row line", 5'h01, fl)
    `CHECK("screen time", 2688, on[0] + on[1])
    ref_pos = pos[0];
    // too small a start lands at the first usable spot; window 1 alone
    cfg(16'h8410, 8'h00, 8'h00, 32'h0000_0001);
    EN2 = 1'b0;
    run_frame();
    `CHECK("clamped start", ref_pos, pos[0])
    `CHECK("col0 wide", 492, len[0])
    `CHECK("w2 hidden", -1, first_line[1])
    cfg(16'h8410, 8'h04, 8'h00, 32'h8000_0000);
    EN1 = 1'b0;
    EN2 = 1'b1;
    run_frame();
    `CHECK("w1 hidden", -1, first_line[0])
    `CHECK("w2 alone", 864, len[1])
    EN1 = 1'b1;
    run_frame();
    `CHECK("start step", ref_pos + 4, pos[0])
    `CHECK("col31 wide", 492, len[0])
    stop_test();
  end
endmodule : osd_window_placement_test
